// ==== seerw_pkg.sv ====
/*
 * Shared constants and types of the serial EEPROM read/write engine.
 * Assumes a 20 MHz system clock; the write cycle count below derives from that rate.
 */
package seerw_pkg;

    // System clock period and self-timed write cycle time
    localparam int SYS_PERIOD_NS = 50;
    localparam int TWR_NS        = 10_000_000;
    localparam int TWR_CYC       = TWR_NS / SYS_PERIOD_NS;

    // Array organisation
    localparam int BLOCK_BYTES   = 256;
    localparam int NUM_BLOCKS    = 4;
    localparam int PAGE_BYTES    = 16;
    localparam int PG_W          = 4;
    localparam int BYTE_BITS     = 8;

    // Control byte layout
    localparam logic [3:0] CTRL_CODE = 4'hA;
    localparam int         RW_POS    = 0;
    localparam int         BLK_POS   = 1;

    // Bit counter marks
    localparam logic [3:0] BIT_FULL  = 4'h8;
    localparam logic [3:0] BIT_LAST  = 4'h7;

    // Bus-side sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RECV,
        ST_ACK,
        ST_SEND,
        ST_MACK,
        ST_WAIT
    } seerw_state_e;

    // Meaning of the next received byte
    typedef enum logic [1:0] {
        K_CTRL,
        K_ADDR,
        K_DATA
    } seerw_kind_e;

endpackage

// ==== seerw_sync.sv ====
/*
 * Two-stage synchroniser for levels crossing into the clock domain of clk.
 * Assumes an active-low asynchronous reset already local to that domain.
 */
`timescale 1ns/1ps

module seerw_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] hold;
    } seerw_sync_s;

    seerw_sync_s sync_r;
    seerw_sync_s sync_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Next state: first stage feeds only the second
    always_comb begin
        sync_nxt.meta = d;
        sync_nxt.hold = sync_r.meta;
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_r <= '0;
        end else begin
            sync_r <= sync_nxt;
        end
    end

    assign q = sync_r.hold;

endmodule

// ==== seerw_engine.sv ====
/*
 * Slave-side access engine of a two-wire serial EEPROM: control byte decode,
 * page write with rollover, self-timed write cycle, acknowledge polling,
 * write protect, current-address, random and sequential reads.
 * Assumes link_clk oversamples the bus pins well above the bus bit rate,
 * and that the bus wire resolves sda_o/sda_oe with a pull-up outside.
 */
// Summary of operation
// - Page write buffers up to 16 bytes, stepping only the low four pointer bits.
// - Excess page-write bytes wrap the page counter and overwrite earlier bytes.
// - Self-timed write starts only at the stop ending a write command.
// - While writing, control bytes get no acknowledge; data line stays released.
// - After the write cycle ends, the polling control byte is acknowledged.
// - Write-protect high blocks all programming; reads still work normally.
// - Address counter holds last accessed location plus one.
// - Read control byte is acknowledged, then one byte from pointer goes out.
// - Master ends a read with no acknowledge and stop; device releases data.
// - Write control plus address then repeated start loads pointer, no programming.
// - Master acknowledge of a read byte makes the next address byte follow.
// - Pointer steps by one after each byte, so whole array reads sequentially.
// - Data line changes only while clock is low, except start and stop.
// - The three unused address pins are ignored entirely.
// - Control byte acknowledged only when upper four bits match the device code.
// - Block-select bits become the top word-address bits; extra bits ignored.
`timescale 1ns/1ps

module seerw_engine #(
    parameter int NUM_BLOCKS = seerw_pkg::NUM_BLOCKS,
    parameter int WR_CYCLES  = seerw_pkg::TWR_CYC
) (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       link_clk,
    input  wire logic       scl,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    input  wire logic       wp,
    input  wire logic [2:0] unused_addr_pins
);
    import seerw_pkg::*;

    localparam int BLK_W     = $clog2(NUM_BLOCKS);
    localparam int ADDR_W    = BYTE_BITS + BLK_W;
    localparam int MEM_BYTES = NUM_BLOCKS * BLOCK_BYTES;
    localparam int CNT_W     = $clog2(WR_CYCLES + 1);

    // Refuse sizes the decode cannot serve
    if (NUM_BLOCKS < 2 || NUM_BLOCKS > 8 || (NUM_BLOCKS & (NUM_BLOCKS - 1)) != 0) begin : g_bad_blk
        $error("NUM_BLOCKS must be 2, 4 or 8");
    end
    if (WR_CYCLES < 1) begin : g_bad_wr
        $error("WR_CYCLES must be at least 1");
    end

    typedef struct packed {
        logic                          req_q;
        logic                          busy;
        logic [CNT_W-1:0]              cnt;
    } seerw_sys_s;

    typedef struct packed {
        logic                          scl_q;
        logic                          sda_q;
        seerw_state_e                  state;
        seerw_kind_e                   kind;
        logic [3:0]                    bitcnt;
        logic [7:0]                    shreg;
        logic [7:0]                    tx;
        logic                          rw;
        logic                          mack;
        logic [BLK_W-1:0]              blk;
        logic [ADDR_W-1:0]             ptr;
        logic [PAGE_BYTES-1:0][7:0]    pbuf;
        logic [PAGE_BYTES-1:0]         pmask;
        logic                          wr_tgl;
        logic                          wr_pend;
        logic                          sda_oe;
        logic                          sda_o;
        logic [MEM_BYTES-1:0][7:0]     mem;
    } seerw_link_s;

    logic        srst_n;
    logic        lrst_n;
    logic        scl_s;
    logic        sda_s;
    logic        wp_s;
    logic        busy_s;
    logic        req_s;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_ev;
    logic        stop_ev;
    logic        busy_eff;
    seerw_sys_s  s_r;
    seerw_sys_s  s_nxt;
    seerw_link_s l_r;
    seerw_link_s l_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and domain crossings

    // Reset asserts at once and releases through two flops per domain
    seerw_sync #(.W(1)) u_srst (
        .clk   (sys_clk),
        .rst_n (nrst),
        .d     (1'b1),
        .q     (srst_n)
    );

    seerw_sync #(.W(1)) u_lrst (
        .clk   (link_clk),
        .rst_n (nrst),
        .d     (1'b1),
        .q     (lrst_n)
    );

    // Bus pins and protect input; unused_addr_pins are never read
    seerw_sync #(.W(3)) u_pins (
        .clk   (link_clk),
        .rst_n (lrst_n),
        .d     ({scl, sda_i, wp}),
        .q     ({scl_s, sda_s, wp_s})
    );

    // Busy level back to the bus side
    seerw_sync #(.W(1)) u_busy (
        .clk   (link_clk),
        .rst_n (lrst_n),
        .d     (s_r.busy),
        .q     (busy_s)
    );

    // Write request toggle into the system domain
    seerw_sync #(.W(1)) u_req (
        .clk   (sys_clk),
        .rst_n (srst_n),
        .d     (l_r.wr_tgl),
        .q     (req_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Self-timed write cycle counter (system domain)

    always_comb begin
        s_nxt = s_r;
        s_nxt.req_q = req_s;
        if (req_s != s_r.req_q) begin
            s_nxt.busy = 1'b1;
            s_nxt.cnt  = CNT_W'(WR_CYCLES - 1);
        end else if (s_r.busy) begin
            if (s_r.cnt == '0) begin
                s_nxt.busy = 1'b0;
            end else begin
                s_nxt.cnt = s_r.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge srst_n) begin
        if (!srst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus conditions seen on the synchronised pins

    assign scl_rise = scl_s & ~l_r.scl_q;
    assign scl_fall = ~scl_s & l_r.scl_q;
    assign start_ev = scl_s & l_r.scl_q & l_r.sda_q & ~sda_s;
    assign stop_ev  = scl_s & l_r.scl_q & ~l_r.sda_q & sda_s;
    // Pending covers the gap until the system domain reports busy
    assign busy_eff = l_r.wr_pend | busy_s;

    ////////////////////////////////////////////////////////////////////////////
    // Bus sequencer, page buffer, pointer and array (link domain)

    always_comb begin
        logic load_rd;
        load_rd = 1'b0;
        l_nxt = l_r;
        l_nxt.scl_q = scl_s;
        l_nxt.sda_q = sda_s;
        if (l_r.wr_pend && busy_s) begin
            l_nxt.wr_pend = 1'b0;
        end
        if (stop_ev) begin
            // Program only buffered bytes, only when not protected
            if (l_r.pmask != '0 && !wp_s) begin
                for (int i = 0; i < PAGE_BYTES; i++) begin
                    if (l_r.pmask[i]) begin
                        l_nxt.mem[{l_r.ptr[ADDR_W-1:PG_W], PG_W'(i)}] = l_r.pbuf[i];
                    end
                end
                l_nxt.wr_tgl  = ~l_r.wr_tgl;
                l_nxt.wr_pend = 1'b1;
            end
            l_nxt.pmask  = '0;
            l_nxt.state  = ST_IDLE;
            l_nxt.sda_oe = 1'b0;
        end else if (start_ev) begin
            // Repeated start drops a half-done write
            l_nxt.pmask  = '0;
            l_nxt.state  = ST_RECV;
            l_nxt.kind   = K_CTRL;
            l_nxt.bitcnt = '0;
            l_nxt.sda_oe = 1'b0;
        end else begin
            case (l_r.state)
                ST_RECV: begin
                    if (scl_rise) begin
                        l_nxt.shreg  = {l_r.shreg[6:0], sda_s};
                        l_nxt.bitcnt = l_r.bitcnt + 1'b1;
                    end else if (scl_fall && l_r.bitcnt == BIT_FULL) begin
                        l_nxt.state  = ST_ACK;
                        l_nxt.sda_oe = 1'b1;
                        case (l_r.kind)
                            K_CTRL: begin
                                // Match code and idle, else stay silent
                                if (l_r.shreg[7:4] != CTRL_CODE || busy_eff) begin
                                    l_nxt.state  = ST_WAIT;
                                    l_nxt.sda_oe = 1'b0;
                                end
                                l_nxt.rw   = l_r.shreg[RW_POS];
                                l_nxt.blk  = l_r.shreg[BLK_POS +: BLK_W];
                                l_nxt.kind = K_ADDR;
                                if (l_r.shreg[RW_POS]) begin
                                    l_nxt.ptr = {l_r.shreg[BLK_POS +: BLK_W],
                                                 l_r.ptr[BYTE_BITS-1:0]};
                                end
                            end
                            K_ADDR: begin
                                l_nxt.ptr  = {l_r.blk, l_r.shreg};
                                l_nxt.kind = K_DATA;
                            end
                            default: begin
                                // Slot from low pointer bits; wrap overwrites
                                l_nxt.pbuf[l_r.ptr[PG_W-1:0]]  = l_r.shreg;
                                l_nxt.pmask[l_r.ptr[PG_W-1:0]] = 1'b1;
                                l_nxt.ptr[PG_W-1:0] = l_r.ptr[PG_W-1:0] + 1'b1;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    // Release or first data bit only after clock falls
                    if (scl_fall) begin
                        l_nxt.sda_oe = 1'b0;
                        l_nxt.bitcnt = '0;
                        if (l_r.rw) begin
                            load_rd = 1'b1;
                        end else begin
                            l_nxt.state = ST_RECV;
                        end
                    end
                end
                ST_SEND: begin
                    if (scl_fall) begin
                        if (l_r.bitcnt == BIT_LAST) begin
                            l_nxt.sda_oe = 1'b0;
                            l_nxt.state  = ST_MACK;
                        end else begin
                            l_nxt.bitcnt = l_r.bitcnt + 1'b1;
                            l_nxt.tx     = {l_r.tx[6:0], 1'b0};
                            l_nxt.sda_oe = ~l_r.tx[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        l_nxt.mack = ~sda_s;
                    end else if (scl_fall) begin
                        l_nxt.bitcnt = '0;
                        if (l_r.mack) begin
                            load_rd = 1'b1;
                        end else begin
                            l_nxt.state = ST_WAIT;
                        end
                    end
                end
                ST_IDLE, ST_WAIT: begin
                    l_nxt.sda_oe = 1'b0;
                end
                default: begin
                    l_nxt.state  = ST_IDLE;
                    l_nxt.sda_oe = 1'b0;
                end
            endcase
        end
        // Fetch at pointer, drive MSB, step full pointer
        if (load_rd) begin
            l_nxt.tx     = l_r.mem[l_r.ptr];
            l_nxt.sda_oe = ~l_r.mem[l_r.ptr][7];
            l_nxt.ptr    = l_r.ptr + 1'b1;
            l_nxt.state  = ST_SEND;
        end
    end

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            l_r <= '0;
        end else begin
            l_r <= l_nxt;
        end
    end

    // Open-drain pin: level is always low, enable pulls the line
    assign sda_oe = l_r.sda_oe;
    assign sda_o  = l_r.sda_o;

    ////////////////////////////////////////////////////////////////////////////
    // Checks and coverage

    logic ctrl_done;
    logic data_done;
    assign ctrl_done = l_r.state == ST_RECV && l_r.kind == K_CTRL && scl_fall
                       && l_r.bitcnt == BIT_FULL && !start_ev && !stop_ev;
    assign data_done = l_r.state == ST_RECV && l_r.kind == K_DATA && scl_fall
                       && l_r.bitcnt == BIT_FULL && !start_ev && !stop_ev;

    chk_busy_nack: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        ctrl_done && busy_eff |=> !l_r.sda_oe && l_r.state == ST_WAIT)
        else $error("control byte acknowledged while busy");

    chk_code_ack: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        ctrl_done && !busy_eff && l_r.shreg[7:4] == CTRL_CODE
        |=> l_r.sda_oe && l_r.state == ST_ACK)
        else $error("matching control byte not acknowledged");

    chk_page_step: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        data_done |=> l_r.ptr[ADDR_W-1:PG_W] == $past(l_r.ptr[ADDR_W-1:PG_W])
        && l_r.ptr[PG_W-1:0] == PG_W'($past(l_r.ptr[PG_W-1:0]) + 1'b1)
        && l_r.pbuf[$past(l_r.ptr[PG_W-1:0])] == $past(l_r.shreg))
        else $error("page pointer or buffer step wrong");

    chk_sda_low_clk: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        $changed(l_r.sda_oe) && !$past(start_ev) && !$past(stop_ev) |-> $past(scl_fall))
        else $error("data line moved outside clock low");

    chk_wp_noprog: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        stop_ev && wp_s |=> $stable(l_r.wr_tgl) && $stable(l_r.mem))
        else $error("array programmed while protected");

    chk_prog_stop: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        $changed(l_r.wr_tgl) |-> $past(stop_ev) && $past(l_r.pmask) != '0)
        else $error("write cycle started without stop");

    chk_rd_incr: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        $rose(l_r.state == ST_SEND) || (l_r.state == ST_SEND && $past(l_r.state) == ST_MACK)
        |-> l_r.ptr == ADDR_W'($past(l_r.ptr) + 1'b1) && l_r.tx == l_r.mem[$past(l_r.ptr)])
        else $error("read byte or pointer step wrong");

    chk_nack_release: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        l_r.state == ST_MACK && scl_fall && !l_r.mack && !start_ev && !stop_ev
        |=> !l_r.sda_oe [*2])
        else $error("data line driven after master nack");

    chk_rstart_drop: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        start_ev |=> l_r.pmask == '0 && $stable(l_r.wr_tgl))
        else $error("repeated start kept pending write");

    chk_busy_hold: assert property (
        @(posedge sys_clk) disable iff (!srst_n)
        $rose(s_r.busy) |-> s_r.cnt == CNT_W'(WR_CYCLES - 1))
        else $error("write cycle count loaded wrong");

    cov_page_prog: cover property (
        @(posedge link_clk) disable iff (!lrst_n) $changed(l_r.wr_tgl));

    cov_seq_read: cover property (
        @(posedge link_clk) disable iff (!lrst_n)
        l_r.state == ST_MACK && scl_fall && l_r.mack);

    cov_poll_nack: cover property (
        @(posedge link_clk) disable iff (!lrst_n) ctrl_done && busy_eff);

    cov_page_wrap: cover property (
        @(posedge link_clk) disable iff (!lrst_n)
        data_done && l_r.pmask[l_r.ptr[PG_W-1:0]]);

endmodule

// ==== seerw_master.sv ====
/*
 * Behavioural two-wire bus master that drives the clock and start/stop.
 * Assumes the bench resolves the data wire from both pull-down enables
 * with a pull-up, and that link_clk paces the bus phases.
 */
`timescale 1ns/1ps

module seerw_master #(
    parameter int HALF = 8
) (
    input  wire logic link_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_oe
);
    // Bus idle from time zero: clock high, data released
    initial begin
        scl    = 1'b1;
        sda_oe = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(negedge link_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // One bus clock: data set while clock low, wire sampled mid-high
    task automatic bit_io(input logic b, output logic s);
        sda_oe = ~b;
        wt(HALF);
        scl = 1'b1;
        wt(HALF / 2);
        s = sda;
        wt(HALF / 2);
        scl = 1'b0;
        wt(2);
    endtask

    // Start or repeated start: data falls while clock high
    task automatic start();
        sda_oe = 1'b0;
        wt(HALF);
        scl = 1'b1;
        wt(HALF);
        sda_oe = 1'b1;
        wt(HALF);
        scl = 1'b0;
        wt(2);
    endtask

    // Stop: data rises while clock high; bus then stands idle
    task automatic stop();
        sda_oe = 1'b1;
        wt(HALF);
        scl = 1'b1;
        wt(HALF);
        sda_oe = 1'b0;
        wt(HALF);
    endtask

    // Byte out, MSB first; ack is 1 when the device pulled the 9th bit low
    task automatic send(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(v[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    // Byte in; last leaves it unacknowledged to end the read
    task automatic recv(input logic last, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            v[i] = s;
        end
        bit_io(last, s);
    endtask
endmodule

// ==== tb_top.sv ====
/*
 * Self-checking bench of the serial EEPROM engine with a bus master model.
 * Assumes WR_CYCLES is shortened so polling after a byte write sees one refusal.
 */
`timescale 1ns/1ps

module tb_top;
    import seerw_pkg::*;

    typedef struct packed {
        logic [9:0] a;
        logic [7:0] d;
        logic [2:0] p;
    } seerw_tbrow_s;

    logic       sys_clk  = 1'b0;
    logic       link_clk = 1'b0;
    logic       nrst     = 1'b0;
    logic       wp       = 1'b0;
    logic [2:0] pins     = 3'h0;
    logic       scl;
    logic       m_oe;
    logic       sda_o;
    logic       sda_oe;
    wire        sda      = ~(sda_oe | m_oe);
    int         n_fail   = 0;
    int         cmp_count = 0;
    int         n;
    logic [7:0] mem [0:1023];
    logic [7:0] q [$];
    seerw_tbrow_s rows [4] = '{'{10'h005, 8'h5A, 3'h0}, '{10'h1FF, 8'hC3, 3'h7},
                               '{10'h2A0, 8'h01, 3'h5}, '{10'h3FE, 8'hFF, 3'h2}};

    always #25 sys_clk = ~sys_clk;
    always #32 link_clk = ~link_clk;

    seerw_engine #(.NUM_BLOCKS(4), .WR_CYCLES(400)) i_dut (
        .sys_clk(sys_clk), .link_clk(link_clk), .nrst(nrst), .scl(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .wp(wp), .unused_addr_pins(pins));

    seerw_master i_master (.link_clk(link_clk), .sda(sda), .scl(scl), .sda_oe(m_oe));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Write command; the model follows the page rollover when unprotected
    task automatic wr(input logic [9:0] a, input logic [7:0] d[$]);
        logic       ack;
        logic [9:0] loc;
        i_master.start();
        i_master.send({CTRL_CODE, 1'b0, a[9:8], 1'b0}, ack);
        check({7'h0, ack}, 8'h01);
        i_master.send(a[7:0], ack);
        check({7'h0, ack}, 8'h01);
        foreach (d[k]) begin
            i_master.send(d[k], ack);
            check({7'h0, ack}, 8'h01);
            loc = {a[9:4], a[3:0] + 4'(k)};
            if (wp === 1'b0) mem[loc] = d[k];
        end
        i_master.stop();
    endtask

    // Random read (cur=0) or current-address read (cur=1) of cnt bytes
    task automatic rd(input logic [9:0] a, input int cnt, input logic cur);
        logic       ack;
        logic [7:0] v;
        i_master.start();
        if (!cur) begin
            i_master.send({CTRL_CODE, 1'b0, a[9:8], 1'b0}, ack);
            i_master.send(a[7:0], ack);
            check({7'h0, ack}, 8'h01);
            i_master.start();
        end
        i_master.send({CTRL_CODE, 1'b0, a[9:8], 1'b1}, ack);
        check({7'h0, ack}, 8'h01);
        for (int k = 0; k < cnt; k++) begin
            i_master.recv(k == cnt - 1, v);
            check(v, mem[a + 10'(k)]);
        end
        i_master.stop();
    endtask

    // Acknowledge polling with a bounded number of tries
    task automatic poll(output int nacks);
        logic ack;
        nacks = 0;
        ack   = 1'b0;
        while (!ack && nacks < 40) begin
            i_master.start();
            i_master.send({CTRL_CODE, 4'h0}, ack);
            i_master.stop();
            if (!ack) nacks++;
        end
        check({7'h0, ack}, 8'h01);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Device must not move the data line while the clock is high
    always @(sda_oe) if (nrst === 1'b1) check({7'h0, scl}, 8'h00);

    // Watchdog
    initial begin
        repeat (100000) @(posedge sys_clk);
        n_fail++;
        finish_test();
    end

    // Main sequence
    initial begin
        logic ack;
        foreach (mem[i]) mem[i] = 8'h00;
        repeat (8) @(posedge sys_clk);
        check({7'h0, sda_oe}, 8'h00);
        @(negedge sys_clk) nrst = 1'b1;
        repeat (10) @(posedge link_clk);
        // Table rows: byte write, poll, random read back, pins varied
        foreach (rows[i]) begin
            @(negedge sys_clk) pins = rows[i].p;
            q = {rows[i].d};
            wr(rows[i].a, q);
            poll(n);
            check({7'h0, n > 0}, 8'h01);
            rd(rows[i].a, 1, 1'b0);
        end
        // Page write of 18 bytes wraps and overwrites the first two
        q = {};
        for (int k = 0; k < 18; k++) q.push_back(8'h20 + 8'(k));
        wr(10'h10E, q);
        i_master.start();
        i_master.send({CTRL_CODE, 4'h3}, ack);
        i_master.stop();
        check({7'h0, ack}, 8'h00);
        poll(n);
        rd(10'h100, 1, 1'b1);
        rd(10'h100, 16, 1'b0);
        // Sequential reads across a block and past the top of the array
        rd(10'h1FF, 3, 1'b0);
        rd(10'h202, 1, 1'b1);
        rd(10'h3FF, 2, 1'b0);
        // Write protect: bytes acknowledged, nothing programmed, no busy
        @(negedge sys_clk) wp = 1'b1;
        q = {8'hEE};
        wr(10'h005, q);
        poll(n);
        check(8'(n), 8'h00);
        rd(10'h005, 1, 1'b0);
        @(negedge sys_clk) wp = 1'b0;
        // Wrong device code is refused
        i_master.start();
        i_master.send(8'hB0, ack);
        i_master.stop();
        check({7'h0, ack}, 8'h00);
        // Mid-run reset: data line released, open-drain level low, array cleared
        @(negedge sys_clk) nrst = 1'b0;
        repeat (8) @(posedge sys_clk);
        check({7'h0, sda_oe}, 8'h00);
        check({7'h0, sda_o}, 8'h00);
        foreach (mem[i]) mem[i] = 8'h00;
        @(negedge sys_clk) nrst = 1'b1;
        repeat (10) @(posedge link_clk);
        rd(10'h005, 1, 1'b0);
        finish_test();
    end
endmodule
